// [logic/qplr_pkg.sv]
// Package with the register map, field layouts and shared types of the queue pointer and limit RAM block.
package qplr_pkg;

   // Register byte addresses; the compare register index 11Fh is kept and scaled by four.
   localparam logic [8:0]  CMP_INDEX        = 9'h11F;
   localparam logic [11:0] CMP_ADDR         = {1'b0, CMP_INDEX, 2'b00};
   localparam logic [11:0] ATTN_ADDR        = 12'h000;
   localparam logic [11:0] PTR_CTRL_ADDR    = 12'h010;
   localparam logic [11:0] PTR_DATA_ADDR    = 12'h014;
   localparam logic [11:0] LIM_CTRL_ADDR    = 12'h018;
   localparam logic [11:0] LIM_DATA_ADDR    = 12'h01C;
   localparam logic [11:0] SM_CTRL_ADDR     = 12'h020;

   // Pointer RAM geometry.
   localparam int          PTR_DEPTH        = 32;
   localparam int          PTR_AW           = 5;
   localparam int          PTR_W            = 28;
   localparam logic [4:0]  PTR_FIRST_RSVD   = 5'h17;

   // Limit RAM geometry: sixteen entries, ten queues in use.
   localparam int          LIM_DEPTH        = 16;
   localparam int          LIM_AW           = 4;
   localparam int          LIM_W            = 9;
   localparam logic [3:0]  LIM_QUEUES       = 4'hA;

   // Service function control word fields.
   localparam int          SVC_ADDR_LSB     = 0;
   localparam int          SVC_WRITE_BIT    = 8;
   localparam int          SVC_BUSY_BIT     = 31;

   // Wrap boundaries in bytes; wrap select bit in the state machine control register.
   localparam logic [27:0] WRAP_1K_MASK     = 28'h00003FF;
   localparam logic [27:0] WRAP_4K_MASK     = 28'h0000FFF;
   localparam int          SM_RUN_BIT       = 0;
   localparam int          SM_WRAP4K_BIT    = 1;

   localparam logic [7:0]  ATTN_RESET       = 8'h00;
   localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;

   // One hardware port request toward a RAM.
   typedef struct packed {
      logic              req;
      logic              wr;
      logic [PTR_AW-1:0] addr;
      logic [PTR_W-1:0]  wdata;
   } qplr_ptr_req_t;

   typedef struct packed {
      logic              req;
      logic [LIM_AW-1:0] addr;
   } qplr_lim_req_t;

   typedef enum logic [1:0] {
      SVC_IDLE = 2'b00,
      SVC_PEND = 2'b01,
      SVC_DONE = 2'b10
   } qplr_svc_state_t;

endpackage : qplr_pkg

// [logic/qplr_ram.sv]
// Small single-port synchronous RAM with registered read data.
`timescale 1ns/100ps
module qplr_ram #(
   parameter int DEPTH = 32,
   parameter int AW    = 5,
   parameter int DW    = 28
) (
   // Clock
   input  wire logic          clk,
   // Access port
   input  wire logic          we,
   input  wire logic [AW-1:0] addr,
   input  wire logic [DW-1:0] wdata,
   output logic      [DW-1:0] rdata
);
   logic [DW-1:0] mem [DEPTH];

   // No reset: contents are undefined until software initialises them.
   always_ff @(posedge clk) begin
      if (we) begin
         mem[addr] <= wdata;
      end
      rdata <= mem[addr];
   end
endmodule : qplr_ram

// [logic/qplr_arb.sv]
// Fixed-priority arbiter that lets hardware ports win over the host service port.
`timescale 1ns/100ps
module qplr_arb (
   // Requests
   input  wire logic hw_a_req,
   input  wire logic hw_b_req,
   input  wire logic host_req,
   // Grants
   output logic      hw_a_gnt,
   output logic      hw_b_gnt,
   output logic      host_gnt
);
   // The host waits for both hardware ports and the request port waits for the indicate port, so the host always yields.
   assign hw_a_gnt = hw_a_req;
   assign hw_b_gnt = hw_b_req & ~hw_a_req;
   assign host_gnt = host_req & ~hw_a_req & ~hw_b_req;
endmodule : qplr_arb

// [logic/qplr_top.sv]
// Queue pointer and limit RAM block with conditional write compare, reached over AHB-Lite.
//
// Notes on behaviour
// - Conditional write changes only bits matching compare.
// - Compare loads on attention read or compare write.
// - Compare register has no reset value.
// - Pointer RAM 32x28, entries 23-31 reserved.
// - Host uses service function; engines access directly.
// - Engines maintain pointers after host initialisation.
// - Pointers supply memory bus addresses.
// - Both engines read limits for ten queues.
// - Wrap at fixed 1k or 4k boundary.
// - Descriptors live in external memory queues.
// - Input descriptor gives location, size, part, status.
// - Device writes confirmation after each job.
// - Byte 0 most significant; bit 7 MSB.
`timescale 1ns/100ps
module qplr_top (
   // AHB-Lite slave
   input  wire logic                         hclk,
   input  wire logic                         hresetn,
   input  wire logic                         hsel,
   input  wire logic [11:0]                  haddr,
   input  wire logic [1:0]                   htrans,
   input  wire logic                         hwrite,
   input  wire logic [2:0]                   hsize,
   input  wire logic [31:0]                  hwdata,
   input  wire logic                         hready,
   output logic      [31:0]                  hrdata,
   output logic                              hreadyout,
   output logic                              hresp,
   // Indicate engine pointer port
   input  wire qplr_pkg::qplr_ptr_req_t      ind_ptr,
   input  wire logic                         ind_advance,
   output logic      [qplr_pkg::PTR_W-1:0]   ind_ptr_rdata,
   output logic                              ind_ptr_gnt,
   // Request engine pointer port
   input  wire qplr_pkg::qplr_ptr_req_t      req_ptr,
   input  wire logic                         req_advance,
   output logic      [qplr_pkg::PTR_W-1:0]   req_ptr_rdata,
   output logic                              req_ptr_gnt,
   // Limit lookups from both engines
   input  wire qplr_pkg::qplr_lim_req_t      ind_lim,
   input  wire qplr_pkg::qplr_lim_req_t      req_lim,
   output logic      [qplr_pkg::LIM_W-1:0]   ind_lim_rdata,
   output logic      [qplr_pkg::LIM_W-1:0]   req_lim_rdata,
   // Status and attention outputs
   output logic                              sm_running,
   output logic      [7:0]                   attn_bits
);
   import qplr_pkg::*;

   logic                   ph_valid_reg;
   logic                   ph_write_reg;
   logic [11:0]            ph_addr_reg;
   logic [7:0]             cmp_reg;
   logic [7:0]             attn_reg;
   logic [31:0]            ptr_ctrl_reg;
   logic [PTR_W-1:0]       ptr_data_reg;
   logic [31:0]            lim_ctrl_reg;
   logic [LIM_W-1:0]       lim_data_reg;
   logic [1:0]             sm_reg;
   qplr_svc_state_t        psvc_reg;
   qplr_svc_state_t        lsvc_reg;
   logic [31:0]            rd_mux;
   logic                   wr_cmp, wr_attn, wr_ptrc, wr_ptrd, wr_limc, wr_limd, wr_sm, rd_attn;
   logic                   host_preq, g_ind, g_req, g_host;
   logic                   ptr_we;
   logic [PTR_AW-1:0]      ptr_addr;
   logic [PTR_W-1:0]       ptr_wdata, ptr_rdata, adv_val;
   logic [LIM_AW-1:0]      lim_addr;
   logic                   lim_we;
   logic [LIM_W-1:0]       lim_rdata;
   logic [1:0]             ptr_owner_reg;
   logic [1:0]             lim_owner_reg;
   logic [27:0]            wrap_mask;

   // Address phase capture; single-cycle answers so hreadyout is always high.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ph_valid_reg <= 1'b0;
         ph_write_reg <= 1'b0;
         ph_addr_reg  <= 12'h000;
      end else if (hready) begin
         ph_valid_reg <= hsel & (htrans == HTRANS_NONSEQ);
         ph_write_reg <= hwrite;
         ph_addr_reg  <= haddr;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   assign wr_cmp  = ph_valid_reg & ph_write_reg & (ph_addr_reg == CMP_ADDR);
   assign wr_attn = ph_valid_reg & ph_write_reg & (ph_addr_reg == ATTN_ADDR);
   assign wr_ptrc = ph_valid_reg & ph_write_reg & (ph_addr_reg == PTR_CTRL_ADDR);
   assign wr_ptrd = ph_valid_reg & ph_write_reg & (ph_addr_reg == PTR_DATA_ADDR);
   assign wr_limc = ph_valid_reg & ph_write_reg & (ph_addr_reg == LIM_CTRL_ADDR);
   assign wr_limd = ph_valid_reg & ph_write_reg & (ph_addr_reg == LIM_DATA_ADDR);
   assign wr_sm   = ph_valid_reg & ph_write_reg & (ph_addr_reg == SM_CTRL_ADDR);
   // Read decode is made in the address phase so the compare sees the value actually returned.
   assign rd_attn = hready & hsel & (htrans == HTRANS_NONSEQ) & ~hwrite & (haddr == ATTN_ADDR);

   // Compare register keeps its value through reset, so it has no reset branch.
   always_ff @(posedge hclk) begin
      if (wr_cmp) begin
         cmp_reg <= hwdata[7:0];
      end else if (rd_attn) begin
         cmp_reg <= attn_reg;
      end
   end

   // Attention register stands in for the conditional event registers held elsewhere.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         attn_reg <= ATTN_RESET;
      end else if (wr_attn) begin
         attn_reg <= (attn_reg & ~(~(attn_reg ^ cmp_reg))) | (hwdata[7:0] & ~(attn_reg ^ cmp_reg));
      end
   end
   assign attn_bits = attn_reg;

   // State machine control: run and wrap size.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sm_reg <= 2'b00;
      end else if (wr_sm) begin
         sm_reg <= hwdata[1:0];
      end
   end
   assign sm_running = sm_reg[SM_RUN_BIT];
   assign wrap_mask  = sm_reg[SM_WRAP4K_BIT] ? WRAP_4K_MASK : WRAP_1K_MASK;

   // Pointer service function: a control write queues an access that waits for a free RAM cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         psvc_reg     <= SVC_IDLE;
         ptr_ctrl_reg <= 32'h00000000;
      end else begin
         case (psvc_reg)
            SVC_IDLE: begin
               if (wr_ptrc) begin
                  ptr_ctrl_reg <= hwdata;
                  psvc_reg     <= SVC_PEND;
               end
            end
            SVC_PEND: begin
               if (g_host) begin
                  psvc_reg <= SVC_DONE;
               end
            end
            SVC_DONE: begin
               psvc_reg <= SVC_IDLE;
            end
            default: psvc_reg <= SVC_IDLE;
         endcase
      end
   end
   assign host_preq = (psvc_reg == SVC_PEND);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ptr_data_reg <= 28'h0000000;
      end else if (wr_ptrd) begin
         ptr_data_reg <= hwdata[PTR_W-1:0];
      end else if (psvc_reg == SVC_DONE && !ptr_ctrl_reg[SVC_WRITE_BIT]) begin
         ptr_data_reg <= ptr_rdata;
      end
   end

   qplr_arb u_arb (
      .hw_a_req (ind_ptr.req),
      .hw_b_req (req_ptr.req),
      .host_req (host_preq),
      .hw_a_gnt (g_ind),
      .hw_b_gnt (g_req),
      .host_gnt (g_host)
   );
   assign ind_ptr_gnt = g_ind;
   assign req_ptr_gnt = g_req;

   // Advance adds one word and wraps inside the fixed queue boundary, never at the limit.
   always_comb begin
      adv_val = g_ind ? ind_ptr.wdata : req_ptr.wdata;
      if ((g_ind && ind_advance) || (g_req && req_advance)) begin
         adv_val = (adv_val & ~wrap_mask) | ((adv_val + 28'h0000004) & wrap_mask);
      end
   end

   always_comb begin
      ptr_we    = 1'b0;
      ptr_addr  = ptr_ctrl_reg[PTR_AW-1:0];
      ptr_wdata = ptr_data_reg;
      if (g_ind) begin
         ptr_we    = ind_ptr.wr;
         ptr_addr  = ind_ptr.addr;
         ptr_wdata = adv_val;
      end else if (g_req) begin
         ptr_we    = req_ptr.wr;
         ptr_addr  = req_ptr.addr;
         ptr_wdata = adv_val;
      end else if (g_host) begin
         ptr_we = ptr_ctrl_reg[SVC_WRITE_BIT] & (ptr_ctrl_reg[PTR_AW-1:0] < PTR_FIRST_RSVD);
      end
   end

   qplr_ram #(.DEPTH(PTR_DEPTH), .AW(PTR_AW), .DW(PTR_W)) u_ptr_ram (
      .clk   (hclk),
      .we    (ptr_we),
      .addr  (ptr_addr),
      .wdata (ptr_wdata),
      .rdata (ptr_rdata)
   );

   // Read data goes only to the port that owned the previous RAM cycle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ptr_owner_reg <= 2'b00;
         ind_ptr_rdata <= 28'h0000000;
         req_ptr_rdata <= 28'h0000000;
      end else begin
         ptr_owner_reg <= {g_req, g_ind};
         if (ptr_owner_reg[0]) begin
            ind_ptr_rdata <= ptr_rdata;
         end
         if (ptr_owner_reg[1]) begin
            req_ptr_rdata <= ptr_rdata;
         end
      end
   end

   // Limit service: pending until a cycle with no engine lookup; the run bit is not checked.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lsvc_reg     <= SVC_IDLE;
         lim_ctrl_reg <= 32'h00000000;
      end else begin
         case (lsvc_reg)
            SVC_IDLE: begin
               if (wr_limc) begin
                  lim_ctrl_reg <= hwdata;
                  lsvc_reg     <= SVC_PEND;
               end
            end
            SVC_PEND: begin
               if (!ind_lim.req && !req_lim.req) begin
                  lsvc_reg <= SVC_DONE;
               end
            end
            SVC_DONE: lsvc_reg <= SVC_IDLE;
            default:  lsvc_reg <= SVC_IDLE;
         endcase
      end
   end

   always_comb begin
      lim_we   = 1'b0;
      lim_addr = lim_ctrl_reg[LIM_AW-1:0];
      if (ind_lim.req) begin
         lim_addr = ind_lim.addr;
      end else if (req_lim.req) begin
         lim_addr = req_lim.addr;
      end else if (lsvc_reg == SVC_PEND) begin
         lim_we = lim_ctrl_reg[SVC_WRITE_BIT] & (lim_ctrl_reg[LIM_AW-1:0] < LIM_QUEUES);
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lim_data_reg <= 9'h000;
      end else if (wr_limd) begin
         lim_data_reg <= hwdata[LIM_W-1:0];
      end else if (lsvc_reg == SVC_DONE && !lim_ctrl_reg[SVC_WRITE_BIT]) begin
         lim_data_reg <= lim_rdata;
      end
   end

   qplr_ram #(.DEPTH(LIM_DEPTH), .AW(LIM_AW), .DW(LIM_W)) u_lim_ram (
      .clk   (hclk),
      .we    (lim_we),
      .addr  (lim_addr),
      .wdata (lim_data_reg),
      .rdata (lim_rdata)
   );

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lim_owner_reg <= 2'b00;
         ind_lim_rdata <= 9'h000;
         req_lim_rdata <= 9'h000;
      end else begin
         // An idle cycle owns no result, so neither port is overwritten with a service read.
         lim_owner_reg <= {req_lim.req & ~ind_lim.req, ind_lim.req};
         if (lim_owner_reg[0]) begin
            ind_lim_rdata <= lim_rdata;
         end
         if (lim_owner_reg[1]) begin
            req_lim_rdata <= lim_rdata;
         end
      end
   end

   // Multi-byte values are returned with byte 0 in the top lane.
   always_comb begin
      rd_mux = 32'h00000000;
      case (ph_addr_reg)
         CMP_ADDR:      rd_mux = {24'h000000, cmp_reg};
         ATTN_ADDR:     rd_mux = {24'h000000, attn_reg};
         PTR_CTRL_ADDR: rd_mux = {(psvc_reg != SVC_IDLE), ptr_ctrl_reg[30:0]};
         PTR_DATA_ADDR: rd_mux = {4'h0, ptr_data_reg};
         LIM_CTRL_ADDR: rd_mux = {(lsvc_reg != SVC_IDLE), lim_ctrl_reg[30:0]};
         LIM_DATA_ADDR: rd_mux = {23'h000000, lim_data_reg};
         SM_CTRL_ADDR:  rd_mux = {30'h00000000, sm_reg};
         default:       rd_mux = 32'h00000000;
      endcase
   end
   assign hrdata = (ph_valid_reg & ~ph_write_reg) ? rd_mux : 32'h00000000;
endmodule : qplr_top

// [verification/qplr_props.sv]
// Checker that watches the ports of the queue pointer and limit RAM block.
`timescale 1ns/100ps
module qplr_props (
   // Bus
   input wire logic                    hclk,
   input wire logic                    hresetn,
   input wire logic                    hsel,
   input wire logic [11:0]             haddr,
   input wire logic [1:0]              htrans,
   input wire logic                    hwrite,
   input wire logic [31:0]             hwdata,
   input wire logic                    hready,
   input wire logic [31:0]             hrdata,
   input wire logic                    hreadyout,
   input wire logic                    hresp,
   // Engines and status
   input wire qplr_pkg::qplr_ptr_req_t ind_ptr,
   input wire qplr_pkg::qplr_ptr_req_t req_ptr,
   input wire logic                    ind_ptr_gnt,
   input wire logic                    req_ptr_gnt,
   input wire logic                    sm_running,
   input wire logic [7:0]              attn_bits
);
   import qplr_pkg::*;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic       dp_v;
   logic       dp_w;
   logic [11:0] dp_a;
   logic [7:0] cmp_sh;
   wire        ap = hsel && hready && htrans == HTRANS_NONSEQ;
   wire        wr_at = dp_v && dp_w && dp_a == ATTN_ADDR;
   wire        wr_sm = dp_v && dp_w && dp_a == SM_CTRL_ADDR;
   wire [7:0]  eq = ~(attn_bits ^ cmp_sh);
   wire [7:0]  at_exp = (attn_bits & ~eq) | (hwdata[7:0] & eq);
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) dp_v <= 1'b0;
      else dp_v <= ap;
   end
   always_ff @(posedge hclk) begin
      dp_w <= hwrite;
      dp_a <= haddr;
   end
   // The shadow has no reset on purpose, so it tracks the compare value across resets.
   always_ff @(posedge hclk) begin
      if (dp_v && dp_w && dp_a == CMP_ADDR) cmp_sh <= hwdata[7:0];
      else if (ap && !hwrite && haddr == ATTN_ADDR) cmp_sh <= attn_bits;
   end
   chk_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready and OKAY");
   chk_idle_rdata: assert property (!(dp_v && !dp_w) |-> hrdata == 32'h0) else $error("read data outside data phase");
   chk_attn_read: assert property (dp_v && !dp_w && dp_a == ATTN_ADDR |-> hrdata[7:0] == attn_bits)
      else $error("attention read data wrong");
   chk_cond_write: assert property (wr_at |=> attn_bits == $past(at_exp)) else $error("conditional write wrong");
   chk_attn_hold: assert property (!wr_at |=> $stable(attn_bits)) else $error("attention changed unasked");
   chk_ind_first: assert property (ind_ptr.req |-> ind_ptr_gnt && !req_ptr_gnt)
      else $error("indicate port not first");
   chk_req_grant: assert property (req_ptr.req && !ind_ptr.req |-> req_ptr_gnt) else $error("request port not granted");
   chk_gnt_cause: assert property (ind_ptr_gnt || req_ptr_gnt |-> ind_ptr.req || req_ptr.req)
      else $error("grant without request");
   chk_run_write: assert property (wr_sm |=> sm_running == $past(hwdata[SM_RUN_BIT])) else $error("run bit wrong");
   chk_run_hold: assert property (!wr_sm |=> $stable(sm_running)) else $error("run bit changed unasked");
endmodule : qplr_props
bind qplr_top qplr_props u_qplr_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
   .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .ind_ptr(ind_ptr), .req_ptr(req_ptr), .ind_ptr_gnt(ind_ptr_gnt), .req_ptr_gnt(req_ptr_gnt),
   .sm_running(sm_running), .attn_bits(attn_bits));

// [verification/qplr_engine_model.sv]
// Far side model that plays the Indicate and Request engines on the RAM ports.
`timescale 1ns/100ps
module qplr_engine_model (
   // Clock and grants
   input  wire logic               hclk,
   input  wire logic               ind_ptr_gnt,
   input  wire logic               req_ptr_gnt,
   // Requests
   output qplr_pkg::qplr_ptr_req_t ind_ptr,
   output qplr_pkg::qplr_ptr_req_t req_ptr,
   output logic                    ind_advance,
   output logic                    req_advance,
   output qplr_pkg::qplr_lim_req_t ind_lim,
   output qplr_pkg::qplr_lim_req_t req_lim
);
   import qplr_pkg::*;
   initial begin
      ind_ptr = '0;
      req_ptr = '0;
      ind_advance = 1'b0;
      req_advance = 1'b0;
      ind_lim = '0;
      req_lim = '0;
   end
   // A request is held until its grant is seen, since the request port loses to the indicate port.
   task automatic op(input logic s, input logic adv, input logic [4:0] a, input logic [27:0] v);
      int n;
      n = 0;
      @(posedge hclk);
      if (s) begin
         req_ptr <= {1'b1, 1'b1, a, v};
         req_advance <= adv;
      end else begin
         ind_ptr <= {1'b1, 1'b1, a, v};
         ind_advance <= adv;
      end
      do begin
         @(posedge hclk);
         n++;
      end while ((s ? req_ptr_gnt : ind_ptr_gnt) !== 1'b1 && n < 20);
      if (n >= 20) begin
         testbench.miscompares++;
         testbench.summarize();
      end
      if (s) req_ptr <= {2'b00, a, ~v};
      else ind_ptr <= {2'b00, a, ~v};
   endtask : op
   // Direct pointer read; the registered result stands one edge after the granted edge.
   task automatic rdp(input logic s, input logic [4:0] a);
      int n;
      n = 0;
      @(posedge hclk);
      if (s) req_ptr <= {1'b1, 1'b0, a, 28'h0000000};
      else ind_ptr <= {1'b1, 1'b0, a, 28'h0000000};
      do begin
         @(posedge hclk);
         n++;
      end while ((s ? req_ptr_gnt : ind_ptr_gnt) !== 1'b1 && n < 20);
      if (n >= 20) begin
         testbench.miscompares++;
         testbench.summarize();
      end
      if (s) req_ptr <= '0;
      else ind_ptr <= '0;
      repeat (2) @(posedge hclk);
   endtask : rdp
   task automatic lk(input logic s, input logic [3:0] a);
      @(posedge hclk);
      if (s) req_lim <= {1'b1, a};
      else ind_lim <= {1'b1, a};
      @(posedge hclk);
      if (s) req_lim <= {1'b0, ~a};
      else ind_lim <= {1'b0, ~a};
      repeat (3) @(posedge hclk);
   endtask : lk
endmodule : qplr_engine_model

// [verification/testbench.sv]
// Self-checking bench for the queue pointer and limit RAM block.
`timescale 1ns/100ps
module testbench;
   import qplr_pkg::*;
   logic hclk, hresetn, hsel, hwrite, ind_advance, req_advance, ind_ptr_gnt, req_ptr_gnt;
   logic hreadyout, hresp, sm_running;
   logic [11:0] haddr;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] hwdata, hrdata, r;
   logic [27:0] ind_ptr_rdata, req_ptr_rdata, dv, m, pv[0:5];
   logic [8:0] ind_lim_rdata, req_lim_rdata, lv[0:9];
   logic [7:0] attn_bits, attn_m, c, d;
   logic [4:0] pa[0:5];
   qplr_ptr_req_t ind_ptr, req_ptr;
   qplr_lim_req_t ind_lim, req_lim;
   wire hready = hreadyout;
   int miscompares, total_checks;
   qplr_top u_qplr_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .ind_ptr(ind_ptr), .ind_advance(ind_advance), .ind_ptr_rdata(ind_ptr_rdata),
      .ind_ptr_gnt(ind_ptr_gnt), .req_ptr(req_ptr), .req_advance(req_advance), .req_ptr_rdata(req_ptr_rdata),
      .req_ptr_gnt(req_ptr_gnt), .ind_lim(ind_lim), .req_lim(req_lim), .ind_lim_rdata(ind_lim_rdata),
      .req_lim_rdata(req_lim_rdata), .sm_running(sm_running), .attn_bits(attn_bits));
   qplr_engine_model u_qplr_engine_model (.hclk(hclk), .ind_ptr_gnt(ind_ptr_gnt), .req_ptr_gnt(req_ptr_gnt),
      .ind_ptr(ind_ptr), .req_ptr(req_ptr), .ind_advance(ind_advance), .req_advance(req_advance),
      .ind_lim(ind_lim), .req_lim(req_lim));
   always #2 hclk = ~hclk;
   function automatic logic [7:0] cw(input logic [7:0] a, input logic [7:0] k, input logic [7:0] v);
      return (a & (a ^ k)) | (v & ~(a ^ k));
   endfunction : cw
   function automatic logic [27:0] adv(input logic [27:0] v, input logic k4);
      logic [27:0] w;
      w = k4 ? WRAP_4K_MASK : WRAP_1K_MASK;
      return (v & ~w) | ((v + 28'h4) & w);
   endfunction : adv
   task automatic summarize;
      if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : summarize
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("Error %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic waitrdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (n >= 50) begin
         miscompares++;
         summarize();
      end
   endtask : waitrdy
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] v, output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= HTRANS_NONSEQ;
      waitrdy();
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= w ? v : ~hwdata;
      waitrdy();
      q = hrdata;
   endtask : bus
   task automatic wr(input logic [11:0] a, input logic [31:0] v);
      logic [31:0] x;
      bus(1'b1, a, v, x);
   endtask : wr
   task automatic rd(input logic [11:0] a, output logic [31:0] q);
      bus(1'b0, a, 32'h0, q);
   endtask : rd
   // Data is read only once busy has dropped, as an earlier read may return a stale entry.
   task automatic svc(input logic [11:0] ca, input logic [31:0] v);
      int n;
      logic [31:0] s;
      n = 0;
      wr(ca, v);
      do begin
         rd(ca, s);
         n++;
      end while (s[SVC_BUSY_BIT] !== 1'b0 && n < 50);
      chk("svc_busy", 32'h0, {31'h0, s[SVC_BUSY_BIT]});
   endtask : svc
   task automatic sw(input logic [11:0] ca, input logic [11:0] da, input logic [4:0] a, input logic [31:0] v);
      wr(da, v);
      svc(ca, {23'h0, 1'b1, 3'h0, a});
   endtask : sw
   task automatic sr(input logic [11:0] ca, input logic [11:0] da, input logic [4:0] a, output logic [31:0] q);
      svc(ca, {27'h0, a});
      rd(da, q);
   endtask : sr
   task automatic rst;
      hresetn <= 1'b0;
      repeat (5) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
   endtask : rst
   initial begin
      hclk = 1'b0;
      hresetn = 1'b0;
      hsel = 1'b0;
      hwrite = 1'b0;
      haddr = 12'h000;
      htrans = 2'h0;
      hsize = 3'h2;
      hwdata = 32'h0;
      miscompares = 0;
      total_checks = 0;
      void'($urandom(32'h3B7B));
      rst();
      wr(12'h040, 32'hFFFFFFFF);
      rd(12'h040, r);
      chk("unmapped", 32'h0, r);
      attn_m = ATTN_RESET;
      for (int i = 0; i < 8; i++) begin
         c = (i == 0) ? ~attn_m : (i == 1) ? attn_m : 8'($urandom);
         d = 8'($urandom);
         wr(CMP_ADDR, {24'h0, c});
         rd(CMP_ADDR, r);
         chk("cmp", {24'h0, c}, r);
         wr(ATTN_ADDR, {24'h0, d});
         attn_m = cw(attn_m, c, d);
         rd(ATTN_ADDR, r);
         chk("attn", {24'h0, attn_m}, r);
         rd(CMP_ADDR, r);
         chk("cmp_load", {24'h0, attn_m}, r);
      end
      wr(CMP_ADDR, 32'h5A);
      rst();
      rd(CMP_ADDR, r);
      chk("cmp_keep", 32'h5A, r);
      rd(ATTN_ADDR, r);
      chk("attn_rst", {24'h0, ATTN_RESET}, r);
      for (int i = 0; i < 6; i++) begin
         pa[i] = (i == 5) ? (PTR_FIRST_RSVD - 5'h1) : 5'(i * 4 + $urandom_range(3));
         pv[i] = 28'($urandom);
         sw(PTR_CTRL_ADDR, PTR_DATA_ADDR, pa[i], {4'h0, pv[i]});
      end
      for (int i = 0; i < 6; i++) begin
         sr(PTR_CTRL_ADDR, PTR_DATA_ADDR, pa[i], r);
         chk("ptr", {4'h0, pv[i]}, r);
      end
      for (int k = 0; k < 2; k++) begin
         wr(SM_CTRL_ADDR, {30'h0, k[0], 1'b1});
         m = k[0] ? WRAP_4K_MASK : WRAP_1K_MASK;
         dv = (28'($urandom) & ~m) | (m - 28'h1);
         u_qplr_engine_model.op(k[0], 1'b1, 5'(k + 2), dv);
         sr(PTR_CTRL_ADDR, PTR_DATA_ADDR, 5'(k + 2), r);
         chk("wrap", {4'h0, adv(dv, k[0])}, r);
      end
      fork
         u_qplr_engine_model.op(1'b0, 1'b0, 5'h4, pv[0]);
         u_qplr_engine_model.op(1'b1, 1'b0, 5'h5, pv[1]);
         sw(PTR_CTRL_ADDR, PTR_DATA_ADDR, 5'h6, {4'h0, pv[2]});
      join
      for (int i = 0; i < 3; i++) begin
         sr(PTR_CTRL_ADDR, PTR_DATA_ADDR, 5'(i + 4), r);
         chk("ptr_mix", {4'h0, pv[i]}, r);
      end
      for (int i = 0; i < 2; i++) begin
         u_qplr_engine_model.rdp(i[0], 5'(i + 4));
         chk("ptr_hw", {4'h0, pv[i]}, {4'h0, i[0] ? req_ptr_rdata : ind_ptr_rdata});
      end
      wr(SM_CTRL_ADDR, 32'h0);
      for (int i = 0; i < 10; i++) begin
         lv[i] = 9'($urandom);
         sw(LIM_CTRL_ADDR, LIM_DATA_ADDR, 5'(i), {23'h0, lv[i]});
      end
      for (int i = 0; i < 10; i++) begin
         sr(LIM_CTRL_ADDR, LIM_DATA_ADDR, 5'(i), r);
         chk("lim", {23'h0, lv[i]}, r);
         u_qplr_engine_model.lk(i[0], 4'(i));
         chk("lim_hw", {23'h0, lv[i]}, {23'h0, i[0] ? req_lim_rdata : ind_lim_rdata});
      end
      summarize();
   end
endmodule : testbench
